//--- hw/cae_core.sv
// Operand addressing, control transfer and execute core
`timescale 1ns/1ns
module cae_core
    import cae_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    output logic [14:0] progAddr,
    input wire logic [7:0] progData,
    output cae_bus_type periphBus,
    input wire logic [7:0] periphRdata,
    input wire logic [3:0] vecIndex,
    output logic swPending,
    output logic gieFlag
);
    cae_state_type st, next_st;
    logic [7:0] ram [RAM_WORDS];
    logic [7:0] a, b, x, sp, processor_status_word, op, op2, op3, memAdr, dirAdr;
    logic [7:0] next_a, next_b, next_x, next_sp, next_psw, next_mem;
    logic [14:0] pc, next_pc, next_pa, target;
    logic dirOn, skipOn;
    logic [1:0] skipCnt;
    logic [7:0] rd, opAdr, aluIn, inv, wrAdr, wrDat, bitMask;
    logic [8:0] sum;
    logic [4:0] half;
    logic cin, wrEn, doSkip;
    logic [3:0] vecSel;

    function automatic logic [6:0] ramIdx(input logic [7:0] ad);
        ramIdx = (ad <= RAM_END) ? ad[6:0] : {3'b111, ad[3:0]};
    endfunction

    function automatic logic isRam(input logic [7:0] ad);
        isRam = (ad <= RAM_END) || (ad >= REG_BASE && ad <= REG_END);
    endfunction

    function automatic logic isExt(input logic [7:0] ad);
        isExt = !isRam(ad) && ad != XP_ADR && ad != SP_ADR && ad != BP_ADR
            && ad != PSW_ADR && !(ad > RAM_END && ad <= ONES_END);
    endfunction

    function automatic logic [1:0] instrLen(input logic [7:0] o);
        casez (o)
            8'hA9, 8'hAC, 8'hAD, 8'hBC: instrLen = 2'd3;
            8'h2?, 8'h3?, 8'h60, 8'h9?, 8'hBD, 8'hD?: instrLen = 2'd2;
            default: instrLen = 2'd1;
        endcase
    endfunction

    // Direct prefix is skipped together with its one-byte operation
    function automatic logic [1:0] skipLen(input logic [7:0] o);
        skipLen = (o == 8'hBD) ? 2'd3 : instrLen(o);
    endfunction

    function automatic logic memOp(input logic [7:0] o);
        casez (o)
            8'b0110_1???, 8'b0111_????, 8'b1000_0???, 8'hC?: memOp = 1'b1;
            8'h8C, 8'h8E, 8'h8F, 8'h9C, 8'h9D, 8'hA9: memOp = 1'b1;
            8'hA2, 8'hA3, 8'hA6, 8'hAA, 8'hAB, 8'hAE: memOp = 1'b1;
            8'hB2, 8'hB3, 8'hB6, 8'hB9, 8'hBA, 8'hBB, 8'hBE: memOp = 1'b1;
            default: memOp = 1'b0;
        endcase
    endfunction

    assign gieFlag = processor_status_word[GIE_BIT];
    assign vecSel = swPending ? SW_VEC : vecIndex;
    assign bitMask = 8'h01 << op[2:0];

    always_comb begin
        if (memAdr == XP_ADR) rd = x;
        else if (memAdr == SP_ADR) rd = sp;
        else if (memAdr == BP_ADR) rd = b;
        else if (memAdr == PSW_ADR) rd = processor_status_word;
        else if (memAdr > RAM_END && memAdr <= ONES_END) rd = 8'hFF;
        else if (isRam(memAdr)) rd = ram[ramIdx(memAdr)];
        else rd = periphRdata;
    end

    always_comb begin
        opAdr = dirOn ? dirAdr : b;
        casez (op)
            8'hB2, 8'hB3, 8'hB6, 8'hBA, 8'hBB, 8'hBE: opAdr = x;
            8'h9C, 8'h9D, 8'hA9, 8'hBC: opAdr = op2;
            8'hC?, 8'hD?: opAdr = {REG_BASE[7:4], op[3:0]};
            8'h8C, 8'h8E, 8'h8F: opAdr = sp + 8'h01;
            default: ;
        endcase
    end

    always_comb begin
        casez (op)
            8'h2?, 8'h3?: target = {pc[14:12], op[3:0], op2};
            8'hAC, 8'hAD: target = {op2[6:0], op3};
            8'h00: target = TRAP_PC;
            default: target = pc + {{7{op[7]}}, op};
        endcase
    end

    assign aluIn = (op[7:4] == 4'h9) ? op2 : rd;

    always_comb begin
        inv = (op[2:0] == 3'd1) ? ~aluIn : aluIn;
        cin = (op[2:0] == 3'd4) ? 1'b0 : processor_status_word[C_BIT];
        sum = {1'b0, a} + {1'b0, inv} + {8'h00, cin};
        half = {1'b0, a[3:0]} + {1'b0, inv[3:0]} + {4'h0, cin};
    end

    always_comb begin
        next_a = a;
        next_b = b;
        next_x = x;
        next_sp = sp;
        next_psw = processor_status_word;
        next_pc = pc;
        next_pa = progAddr;
        next_mem = memAdr;
        next_st = ST_FETCH;
        wrEn = 1'b0;
        wrAdr = memAdr;
        wrDat = a;
        doSkip = 1'b0;
        case (st)
            ST_FETCH: begin
                next_pc = pc + 15'h0001;
                if (skipOn) next_st = (skipLen(progData) == 2'd1) ? ST_FETCH : ST_SKIP;
                else next_st = (instrLen(progData) == 2'd1) ? ST_ADDR : ST_OPND1;
            end
            ST_SKIP: begin
                next_pc = pc + 15'h0001;
                next_st = (skipCnt == 2'd1) ? ST_FETCH : ST_SKIP;
            end
            ST_OPND1: begin
                next_pc = pc + 15'h0001;
                next_st = (instrLen(op) == 2'd3) ? ST_OPND2 : ST_ADDR;
            end
            ST_OPND2: begin
                next_pc = pc + 15'h0001;
                next_st = ST_ADDR;
            end
            ST_ADDR: begin
                next_mem = opAdr;
                next_st = ST_EXEC;
                next_pa = (op == 8'hB4) ? VEC_BASE + {10'h000, vecSel, 1'b0} : {pc[14:8], a};
            end
            ST_EXEC: begin
                casez (op)
                    8'h00, 8'h3?, 8'hAD: begin
                        wrEn = 1'b1;
                        wrAdr = sp;
                        wrDat = pc[7:0];
                        next_st = ST_PUSH2;
                    end
                    8'h0?, 8'h1?, 8'h2?, 8'hAC, 8'hE?, 8'hF?: next_pc = target;
                    8'h4?: doSkip = (b[3:0] == op[3:0]);
                    8'h5?: next_b = {4'h0, ~op[3:0]};
                    8'h60: doSkip = ((a & op2) == 8'h00);
                    8'h64: next_a = 8'h00;
                    8'h67: begin
                        wrEn = 1'b1;
                        wrAdr = sp;
                        next_sp = sp - 8'h01;
                    end
                    8'b0110_1???: begin
                        wrEn = 1'b1;
                        wrDat = rd & ~bitMask;
                    end
                    8'b0111_0???: doSkip = !rd[op[2:0]];
                    8'b0111_1???: begin
                        wrEn = 1'b1;
                        wrDat = rd | bitMask;
                    end
                    8'b100?_0???: begin
                        case (op[2:0])
                            3'd0, 3'd1: begin
                                next_a = sum[7:0];
                                next_psw[C_BIT] = sum[8];
                                next_psw[HC_BIT] = half[4];
                            end
                            3'd2: doSkip = (a != aluIn);
                            3'd3: doSkip = !(a > aluIn);
                            3'd4: next_a = sum[7:0];
                            3'd5: next_a = a & aluIn;
                            3'd6: next_a = a ^ aluIn;
                            default: next_a = a | aluIn;
                        endcase
                    end
                    8'h99, 8'hB9: doSkip = (a == aluIn);
                    8'hA9: doSkip = (rd != op3);
                    8'h98, 8'h9F: begin
                        next_a = (op == 8'h98) ? op2 : a;
                        next_b = (op == 8'h9F) ? op2 : b;
                    end
                    8'h8A: next_a = a + 8'h01;
                    8'h8B: next_a = a - 8'h01;
                    8'h8C: begin
                        next_a = rd;
                        next_sp = sp + 8'h01;
                    end
                    8'h8E, 8'h8F: begin
                        next_pc = {rd[6:0], pc[7:0]};
                        next_mem = sp + 8'h02;
                        next_st = ST_POP2;
                    end
                    8'h9A, 8'h9B, 8'h9E, 8'hD?: begin
                        wrEn = 1'b1;
                        wrDat = op2;
                    end
                    8'hBC: begin
                        wrEn = 1'b1;
                        wrDat = op3;
                    end
                    8'hA0, 8'hA1: begin
                        next_psw[C_BIT] = op[0];
                        next_psw[HC_BIT] = op[0];
                    end
                    8'hA4: next_a = progData;
                    8'hA5: next_pc = {pc[14:8], progData};
                    8'hB4: begin
                        next_pc = {progData[6:0], pc[7:0]};
                        next_pa = progAddr + 15'h0001;
                        next_st = ST_VEC2;
                    end
                    8'hA2, 8'hA3, 8'hA6, 8'hB2, 8'hB3, 8'hB6, 8'h9C: begin
                        next_a = rd;
                        wrEn = 1'b1;
                    end
                    8'hAA, 8'hAB, 8'hAE, 8'hBA, 8'hBB, 8'hBE, 8'h9D: next_a = rd;
                    8'hC?: begin
                        wrEn = 1'b1;
                        wrDat = rd - 8'h01;
                        doSkip = (rd == 8'h01);
                    end
                    default: ;
                endcase
                case (op)
                    8'hA2, 8'hAA, 8'h9A: next_b = b + 8'h01;
                    8'hA3, 8'hAB, 8'h9B: next_b = b - 8'h01;
                    8'hB2, 8'hBA: next_x = x + 8'h01;
                    8'hB3, 8'hBB: next_x = x - 8'h01;
                    default: ;
                endcase
            end
            ST_PUSH2: begin
                wrEn = 1'b1;
                wrAdr = sp - 8'h01;
                wrDat = {1'b0, pc[14:8]};
                next_sp = sp - 8'h02;
                next_pc = target;
            end
            ST_POP2: begin
                next_pc = {pc[14:8], rd};
                next_sp = sp + 8'h02;
                if (op == 8'h8F) next_psw[GIE_BIT] = 1'b1;
            end
            ST_VEC2: next_pc = {pc[14:8], progData};
            default: ;
        endcase
        if (next_st != ST_EXEC && next_st != ST_VEC2) next_pa = next_pc;
        // Register writes through data space win over post steps
        if (wrEn && wrAdr == XP_ADR) next_x = wrDat;
        if (wrEn && wrAdr == SP_ADR) next_sp = wrDat;
        if (wrEn && wrAdr == BP_ADR) next_b = wrDat;
        if (wrEn && wrAdr == PSW_ADR) next_psw = wrDat;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            a <= BYTE_RST;
            b <= BYTE_RST;
            x <= BYTE_RST;
            sp <= SP_RST;
            processor_status_word <= BYTE_RST;
        end else begin
            a <= next_a;
            b <= next_b;
            x <= next_x;
            sp <= next_sp;
            processor_status_word <= next_psw;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= ST_FETCH;
            pc <= PC_RST;
            progAddr <= PC_RST;
            op <= BYTE_RST;
            op2 <= BYTE_RST;
            op3 <= BYTE_RST;
            memAdr <= BYTE_RST;
            skipOn <= 1'b0;
            skipCnt <= 2'd0;
            dirOn <= 1'b0;
            dirAdr <= BYTE_RST;
        end else begin
            st <= next_st;
            pc <= next_pc;
            progAddr <= next_pa;
            memAdr <= next_mem;
            if (st == ST_FETCH && !skipOn) op <= progData;
            if (st == ST_OPND1) op2 <= progData;
            if (st == ST_OPND2) op3 <= progData;
            if (st == ST_FETCH && skipOn) skipCnt <= skipLen(progData) - 2'd1;
            if (st == ST_SKIP) skipCnt <= skipCnt - 2'd1;
            if (st == ST_EXEC) skipOn <= doSkip;
            else if (st == ST_FETCH) skipOn <= 1'b0;
            // Prefix redirects only the one following operation
            if (st == ST_EXEC) dirOn <= (op == 8'hBD);
            if (st == ST_EXEC && op == 8'hBD) dirAdr <= op2;
        end
    end

    // Memory contents are left uninitialised, as in a real RAM
    always_ff @(posedge clk) begin
        if (wrEn && isRam(wrAdr)) ram[ramIdx(wrAdr)] <= wrDat;
    end

    // Peripheral answer must arrive in the same cycle as the strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            periphBus <= '0;
        end else begin
            periphBus.wr <= wrEn && isExt(wrAdr);
            periphBus.rd <= (next_st == ST_EXEC || next_st == ST_POP2) && !wrEn
                && memOp(op) && isExt(next_mem);
            periphBus.adr <= wrEn ? wrAdr : next_mem;
            periphBus.dat <= wrDat;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) swPending <= 1'b0;
        else if (st == ST_EXEC && op == 8'h00) swPending <= 1'b1;
        else if (st == ST_EXEC && op == 8'hB5) swPending <= 1'b0;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_sp_rst;
        $past(rst) |-> sp == SP_RST;
    endproperty
    a_sp_rst: assert property (p_sp_rst) else $error("stack pointer not reset");

    property p_jmp;
        (st == ST_EXEC && op[7:4] == 4'h2) |=> pc[14:12] == $past(pc[14:12])
            && pc[11:0] == {$past(op[3:0]), $past(op2)};
    endproperty
    a_jmp: assert property (p_jmp) else $error("absolute jump target wrong");

    property p_long_jump;
        (st == ST_EXEC && op == 8'hAC) |=> pc == {$past(op2[6:0]), $past(op3)};
    endproperty
    a_long_jump: assert property (p_long_jump) else $error("long jump target wrong");

    property p_ones;
        (st == ST_EXEC && (op == 8'hAE || op == 8'h9D) && memAdr > RAM_END
            && memAdr <= ONES_END)
            |=> a == 8'hFF;
    endproperty
    a_ones: assert property (p_ones) else $error("gap read not all ones");

    property p_and_skip_zero_op;
        (st == ST_EXEC && op == 8'h60 && (a & op2) == 8'h00) |=> skipOn;
    endproperty
    a_and_skip_zero_op: assert property (p_and_skip_zero_op) else $error("and skip missed");

    property p_pointer_nibble_compare;
        (st == ST_EXEC && op[7:4] == 4'h4) |=> skipOn == ($past(b[3:0]) == $past(op[3:0]));
    endproperty
    a_pointer_nibble_compare: assert property (p_pointer_nibble_compare) else $error("nibble compare wrong");

    property p_skip2;
        (st == ST_FETCH && skipOn && skipLen(progData) == 2'd2)
            |=> st == ST_SKIP ##1 (st == ST_FETCH && pc == $past(pc, 2) + 15'h0002);
    endproperty
    a_skip2: assert property (p_skip2) else $error("skip length wrong");

    property p_trap;
        (st == ST_EXEC && op == 8'h00) |=> st == ST_PUSH2 ##1 (pc == TRAP_PC && swPending);
    endproperty
    a_trap: assert property (p_trap) else $error("trap not taken");

    property p_ldb;
        (st == ST_EXEC && op[7:4] == 4'h5) |=> b == {4'h0, ~$past(op[3:0])};
    endproperty
    a_ldb: assert property (p_ldb) else $error("short pointer load wrong");

    property p_table_read_op;
        (st == ST_ADDR && op == 8'hA4) |=> progAddr == {$past(pc[14:8]), $past(a)}
            ##1 a == $past(progData);
    endproperty
    a_table_read_op: assert property (p_table_read_op) else $error("table read wrong");

    property p_pending_clear_op;
        (st == ST_EXEC && op == 8'hB5) |=> !swPending;
    endproperty
    a_pending_clear_op: assert property (p_pending_clear_op) else $error("pending not cleared");

    c_skip: cover property (st == ST_SKIP);
    c_call: cover property (st == ST_PUSH2 && op != 8'h00);
    c_ret: cover property (st == ST_POP2);
    c_vis: cover property (st == ST_VEC2);
endmodule // cae_core

//--- pkg/cae_pkg.sv
// Constants and types shared by the addressing and execute core
// How it works
// - Indirect operands come from data memory at the first or second pointer.
// - Post-modify load and exchange access first, then step the pointer.
// - Direct mode takes the operand address from an 8-bit instruction field.
// - Immediate mode takes the operand from an 8-bit instruction field.
// - Short first-pointer load takes its value from a 4-bit opcode field.
// - Table read fetches program byte at upper PC and accumulator into accumulator.
// - Short relative jump adds -32 to +31 to all 15 PC bits.
// - Absolute jump and call replace only the low 12 PC bits.
// - Long jump and call replace all 15 PC bits.
// - Indirect jump loads fetched program byte into the low PC byte.
// - Vector dispatch loads a two-byte vector from adjacent program addresses.
// - PC is 15 bits as 7 upper and 8 lower; other registers 8 bits.
// - Add and subtract with carry include carry and update carry and half carry.
// - And-skip-zero skips next instruction when masked accumulator is zero.
// - Equal and unequal compares skip next instruction when relation fails.
// - Nibble compare skips unless low first-pointer bits differ from immediate.
// - Decrement-skip-zero decrements F0 to FF location, skips on zero.
// - Bit set and clear force one selected bit, others unchanged.
// - Pending clear resets the software interrupt pending flag.
// - Exchange swaps accumulator and memory, direct or pointer addressed.
// - RAM at 00 to 6F, register RAM at F0 to FB, all in data space.
// - Reads of 70 to 7F return all ones.
// - Stack pointer resets to 6F; stack grows down on pushes.
// - Opcode zero traps as software interrupt.
package cae_pkg;
    localparam logic [7:0] PSW_ADR = 8'hEF;
    localparam logic [7:0] XP_ADR = 8'hFC;
    localparam logic [7:0] SP_ADR = 8'hFD;
    localparam logic [7:0] BP_ADR = 8'hFE;
    localparam logic [7:0] RAM_END = 8'h6F;
    localparam logic [7:0] ONES_END = 8'h7F;
    localparam logic [7:0] REG_BASE = 8'hF0;
    localparam logic [7:0] REG_END = 8'hFB;
    localparam logic [7:0] SP_RST = 8'h6F;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [14:0] PC_RST = 15'h0000;
    localparam logic [14:0] TRAP_PC = 15'h00FF;
    localparam logic [14:0] VEC_BASE = 15'h01E0;
    localparam logic [3:0] SW_VEC = 4'hF;
    localparam int C_BIT = 7;
    localparam int HC_BIT = 6;
    localparam int GIE_BIT = 0;
    localparam int RAM_WORDS = 128;
    typedef enum {ST_FETCH, ST_OPND1, ST_OPND2, ST_ADDR, ST_EXEC, ST_PUSH2, ST_POP2,
                  ST_VEC2, ST_SKIP} cae_state_type;
    typedef struct packed {
        logic [7:0] adr;
        logic [7:0] dat;
        logic rd;
        logic wr;
    } cae_bus_type;
endpackage

//--- tb/cae_mem_model.sv
// Program memory and data-space model facing the core
`timescale 1ns/1ns
module cae_mem_model
    import cae_pkg::*;
(
    input wire logic clk,
    input wire cae_bus_type periphBus,
    input wire logic [14:0] progAddr,
    output logic [7:0] progData,
    output logic [7:0] periphRdata
);
    logic [7:0] rom [0:32767];
    logic [7:0] dmem [0:255];
    logic [7:0] lastRd;
    initial begin
        for (int i = 0; i < 256; i++)
            dmem[i] = i[7:0] ^ 8'h5A;
        lastRd = 8'h00;
    end
    // ROM is loaded by the bench, blank cells read zero
    assign progData = rom[progAddr];
    // Released bus shows inverse of last value so stale data cannot pass
    assign periphRdata = periphBus.rd ? dmem[periphBus.adr] : ~lastRd;
    always @(posedge clk) begin
        if (periphBus.rd)
            lastRd <= dmem[periphBus.adr];
        if (periphBus.wr)
            dmem[periphBus.adr] <= periphBus.dat;
    end
endmodule // cae_mem_model

//--- tb/cae_core_tb.sv
// Self-checking bench for the addressing and execute core
`timescale 1ns/1ns
module cae_core_tb
    import cae_pkg::*;
;
    logic clk;
    logic rst;
    logic [14:0] progAddr;
    logic [7:0] progData;
    cae_bus_type periphBus;
    logic [7:0] periphRdata;
    logic [3:0] vecIndex;
    logic swPending;
    logic gieFlag;
    logic swSeen;
    logic [31:0] seed;
    logic [15:0] expq [$];
    int fail_count;
    int check_count;
    int pc;
    cae_core cae_core_inst (.clk(clk), .rst(rst), .progAddr(progAddr), .progData(progData),
        .periphBus(periphBus), .periphRdata(periphRdata), .vecIndex(vecIndex),
        .swPending(swPending), .gieFlag(gieFlag));
    cae_mem_model cae_mem_model_inst (.clk(clk), .periphBus(periphBus),
        .progAddr(progAddr), .progData(progData), .periphRdata(periphRdata));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    function automatic logic [7:0] dmv(input logic [7:0] a);
        return a ^ 8'h5A;
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Up to eight program bytes per call, first byte in the highest used lane
    task automatic op(input int n, input logic [63:0] v);
        for (int i = n - 1; i >= 0; i--) begin
            cae_mem_model_inst.rom[pc[14:0]] = v[8*i+:8];
            pc++;
        end
    endtask
    // Exchange with a port location publishes the accumulator
    task automatic rep(input logic [7:0] v);
        op(2, 24'h009CD0);
        expq.push_back({8'hD0, v});
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #100000;
        fail_count++;
        end_of_test();
    end
    always @(posedge clk) begin
        if (swPending === 1'b1)
            swSeen <= 1'b1;
        if (!rst && periphBus.wr === 1'b1) begin
            chk({periphBus.adr, periphBus.dat}, expq.size() ? expq.pop_front() : 'x);
            $display("check %0d done", check_count);
        end
    end
    initial begin
        logic [7:0] r1;
        logic [7:0] r2;
        int p;
        rst = 1'b1;
        vecIndex = 4'h0;
        swSeen = 1'b0;
        fail_count = 0;
        check_count = 0;
        pc = 0;
        seed = 32'hCFA2DA88;
        for (int i = 0; i < 32768; i++)
            cae_mem_model_inst.rom[i] = 8'h00;
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            r1 = seed[7:0];
            r2 = seed[15:8];
            op(5, {24'h0, 8'h98, r1, 8'hA0, 8'h90, r2});
            rep(8'(r1 + r2));
            op(5, {24'h0, 8'h98, r1, 8'hA1, 8'h91, r2});
            rep(8'(r1 - r2));
        end
        op(7, 64'hA0_98_F0_90_18_9D_EF);
        rep(8'h80);
        op(6, 64'h98_05_92_05_98_07);
        rep(8'h07);
        op(3, 24'h980799);
        op(3, 24'h079809);
        rep(8'h07);
        op(3, 24'h980760);
        op(2, 24'h00088A);
        rep(8'h07);
        op(3, 24'h5C9807);
        op(2, 24'h00438A);
        rep(8'h07);
        op(3, 24'h980744);
        op(1, 24'h00008A);
        rep(8'h08);
        op(3, 24'h9FD1AA);
        rep(dmv(8'hD1));
        op(1, 24'h0000AE);
        rep(dmv(8'hD2));
        op(2, 24'h009DC5);
        rep(dmv(8'hC5));
        op(2, 24'h009D75);
        rep(8'hFF);
        op(3, 24'h98669C);
        op(3, 24'h109D10);
        rep(8'h66);
        op(3, 24'hBCF502);
        op(3, 24'h9800C5);
        op(3, 24'h8AC58A);
        rep(8'h01);
        op(3, 24'h9FD37A);
        op(1, 24'h000068);
        expq.push_back({8'hD3, dmv(8'hD3) | 8'h04});
        expq.push_back({8'hD3, (dmv(8'hD3) | 8'h04) & 8'hFE});
        cae_mem_model_inst.rom[15'h00E0] = 8'h77;
        op(3, 24'h98E0A4);
        rep(8'h77);
        op(3, 24'h98E1A5);
        cae_mem_model_inst.rom[15'h00E1] = 8'(pc + 1);
        op(1, 24'h00008A);
        rep(8'hE1);
        op(2, 24'h002200);
        pc = 32'h200;
        op(3, 24'h985501);
        op(1, 24'h00008A);
        rep(8'h55);
        op(3, 24'hAC1234);
        pc = 32'h1234;
        op(3, 24'hAD3000);
        p = pc;
        pc = 32'h3000;
        op(3, 24'h98428E);
        pc = p;
        rep(8'h42);
        op(2, 24'h009DFD);
        rep(8'h6F);
        op(2, 24'h0000FF);
        pc = 32'hFF;
        op(1, 24'h0000B4);
        pc = 32'h1FE;
        op(2, 24'h000400);
        pc = 32'h400;
        op(2, 24'h009DFD);
        rep(8'h6D);
        op(2, 24'h00B58F);
        repeat (5) @(posedge clk);
        #1 rst = 1'b0;
        for (int i = 0; i < 5000 && expq.size() > 0; i++) begin
            @(posedge clk);
            #1 seed = xs(seed);
            vecIndex = seed[3:0];
        end
        repeat (20) @(posedge clk);
        chk(16'(expq.size()), 16'h0000);
        chk({15'h0, swSeen}, 16'h0001);
        chk({15'h0, swPending}, 16'h0000);
        chk({15'h0, gieFlag}, 16'h0001);
        end_of_test();
    end
endmodule // cae_core_tb
